// File: design/sqp_pkg.sv
// Purpose: shared constants and carriers for the spi slave queue port
// Assumes: apb with 32-bit data, one aligned word per register
// Notes: queues are held in local arrays sized for the largest length
package sqp_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_QLEN = 8'h04;
    localparam logic [7:0] OFS_THRESH = 8'h08;
    localparam logic [7:0] OFS_TIMEOUT = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_QRESET = 8'h18;
    localparam logic [7:0] OFS_TX_DATA = 8'h1c;
    localparam logic [7:0] OFS_RX_DATA = 8'h20;
    localparam logic [7:0] OFS_FILL = 8'h24;
    localparam logic [7:0] OFS_STATUS = 8'h28;
    // control fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_LSB_FIRST_BIT = 1;
    // interrupt source positions
    localparam int IRQ_RX_FIRST = 0;
    localparam int IRQ_TX_FINAL = 1;
    localparam int IRQ_RX_RISE = 2;
    localparam int IRQ_TX_DROP = 3;
    localparam int IRQ_RX_OVF = 4;
    localparam int IRQ_TX_OVF = 5;
    localparam int IRQ_RX_UNF = 6;
    localparam int IRQ_TX_UNF = 7;
    localparam int IRQ_RX_TMO = 8;
    localparam int IRQ_COUNT = 9;
    // status word positions
    localparam int STAT_RX_NONEMPTY = 0;
    localparam int STAT_TX_NONEMPTY = 1;
    localparam int STAT_RX_OVER_TH = 2;
    localparam int STAT_TX_OVER_TH = 3;
    // reset values
    localparam logic [7:0] QLEN_RESET = 8'hff;
    localparam logic [7:0] THRESH_RESET = 8'h00;
    localparam logic [11:0] TIMEOUT_RESET = 12'h000;
    // timing: one microsecond in pclk cycles at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int US_CYCLES = CLK_MHZ;
    // configuration carrier
    typedef struct packed {
        logic enable;
        logic low_bit_first_order;
        logic [7:0] tx_queue_length;
        logic [7:0] rx_queue_length;
        logic [7:0] tx_fill_threshold;
        logic [7:0] rx_fill_threshold;
        logic [11:0] rx_idle_timeout_us;
    } sqp_cfg_s;
endpackage : sqp_pkg

// File: design/sqp_spi_slave.sv
// Purpose: spi slave port with transmit and receive byte queues behind apb
// Assumes: spi mode 0, master drives sck, select low-active, mosi; pins async
// Notes: miso is a two-way style pin with an active-low output enable
//
// What this block does
// - bytes shift lsb first or msb first per a configured bit order
// - transmit queue length programmable from 1 to 255 bytes
// - receive queue length programmable from 1 to 255 bytes
// - transmit fill threshold 0 to 255 compared with transmit fill
// - receive fill threshold 0 to 255 compared with receive fill
// - receive idle timeout programmable 0 to 4095 microseconds
// - nine-bit interrupt enable mask in the fixed source order
// - disable takes the slave out of service until re-enabled
// - each queue resets alone or both together on separate requests
// - queue reset clears pointers and fill, keeps stored bytes
// - software byte write appends one byte to transmit queue
// - software byte read pops the oldest received byte
// - transmit fill level is readable
// - receive fill level is readable
// - status bit 0 receive not empty, bit 1 transmit not empty
// - status bits 2 and 3 show fill above threshold
// - one interrupt output high while an enabled source is pending
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps
module sqp_spi_slave #(
    parameter int DEPTH = 255,
    parameter int US_CYCLES = sqp_pkg::US_CYCLES
) (
    // system
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // spi link
    input wire logic spi_sck,
    input wire logic spi_sel_n,
    input wire logic spi_mosi,
    output logic spi_miso_o,
    output logic spi_miso_oe_n,
    // interrupt
    output logic irq
);
    initial
    begin
        // queue lengths are programmable up to 255, so the store must hold all of them
        if (DEPTH != 255 || US_CYCLES < 1 || US_CYCLES > 128)
            $error("sqp_spi_slave: unsupported parameter value");
    end

    ////////////////////////////////////////////////////////////////////
    // synchronisers and edge detect
    logic [2:0] sck_s_q;
    logic [1:0] sel_s_q;
    logic [1:0] mosi_s_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sck_s_q <= 3'h0;
            sel_s_q <= 2'h3;
            mosi_s_q <= 2'h0;
        end
        else
        begin
            sck_s_q <= {sck_s_q[1:0], spi_sck};
            sel_s_q <= {sel_s_q[0], spi_sel_n};
            mosi_s_q <= {mosi_s_q[0], spi_mosi};
        end
    end
    sqp_pkg::sqp_cfg_s cfg_q;
    // edges only count inside a frame and while enabled
    wire logic frame = !sel_s_q[1] && cfg_q.enable;
    wire logic sck_rise = frame && sck_s_q[1] && !sck_s_q[2];
    wire logic sck_fall = frame && !sck_s_q[1] && sck_s_q[2];

    ////////////////////////////////////////////////////////////////////
    // apb decode
    wire logic acc = psel && penable;
    wire logic mapped = paddr[7:2] <= sqp_pkg::OFS_STATUS[7:2] && paddr[1:0] == 2'h0;
    // side effects act once, at the edge where pready is seen high
    wire logic wr = acc && pready && pwrite && mapped;
    wire logic rd = acc && pready && !pwrite && mapped;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a[7:2] == o[7:2];
    endfunction : hit
    wire logic tx_push = wr && hit(paddr, sqp_pkg::OFS_TX_DATA);
    wire logic rx_pop = rd && hit(paddr, sqp_pkg::OFS_RX_DATA);
    wire logic qrst_w = wr && hit(paddr, sqp_pkg::OFS_QRESET);
    wire logic tx_qrst = qrst_w && pwdata[0];
    wire logic rx_qrst = qrst_w && pwdata[1];

    ////////////////////////////////////////////////////////////////////
    // configuration registers
    logic [8:0] irq_en_q;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_q <= '{1'b0, 1'b0, sqp_pkg::QLEN_RESET, sqp_pkg::QLEN_RESET,
                       sqp_pkg::THRESH_RESET, sqp_pkg::THRESH_RESET,
                       sqp_pkg::TIMEOUT_RESET};
            irq_en_q <= 9'h000;
        end
        else if (wr)
        begin
            if (hit(paddr, sqp_pkg::OFS_CTRL))
            begin
                cfg_q.enable <= pwdata[sqp_pkg::CTRL_ENABLE_BIT];
                cfg_q.low_bit_first_order <= pwdata[sqp_pkg::CTRL_LSB_FIRST_BIT];
            end
            // zero length is refused and the old length kept
            if (hit(paddr, sqp_pkg::OFS_QLEN))
            begin
                if (pwdata[7:0] != 8'h00)
                    cfg_q.tx_queue_length <= pwdata[7:0];
                if (pwdata[15:8] != 8'h00)
                    cfg_q.rx_queue_length <= pwdata[15:8];
            end
            if (hit(paddr, sqp_pkg::OFS_THRESH))
            begin
                cfg_q.tx_fill_threshold <= pwdata[7:0];
                cfg_q.rx_fill_threshold <= pwdata[15:8];
            end
            if (hit(paddr, sqp_pkg::OFS_TIMEOUT))
                cfg_q.rx_idle_timeout_us <= pwdata[11:0];
            if (hit(paddr, sqp_pkg::OFS_IRQ_EN))
                irq_en_q <= pwdata[8:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // queue storage; resets leave contents alone
    logic [7:0] tx_mem [0:DEPTH-1];
    logic [7:0] rx_mem [0:DEPTH-1];
    logic [7:0] tx_wp_q, tx_rp_q, tx_fill_q;
    logic [7:0] rx_wp_q, rx_rp_q, rx_fill_q;
    function automatic logic [7:0] wrap(input logic [7:0] p, input logic [7:0] len);
        return (p + 8'h01 >= len) ? 8'h00 : p + 8'h01;
    endfunction : wrap
    // shifter state
    logic [2:0] bit_cnt_q;
    logic [7:0] rx_sh_q, tx_sh_q;
    logic byte_done;
    logic tx_load;
    logic tx_got_q;
    wire logic tx_full = tx_fill_q >= cfg_q.tx_queue_length;
    wire logic rx_full = rx_fill_q >= cfg_q.rx_queue_length;
    wire logic tx_empty = tx_fill_q == 8'h00;
    wire logic rx_empty = rx_fill_q == 8'h00;
    wire logic tx_push_ok = tx_push && !tx_full;
    // pop only when the loaded byte starts to go out, so a prefetch at frame end is not lost
    wire logic tx_pop_ok = sck_rise && bit_cnt_q == 3'h0 && tx_got_q && !tx_empty;
    wire logic rx_push_ok = byte_done && !rx_full;
    wire logic rx_pop_ok = rx_pop && !rx_empty;
    logic [7:0] rx_byte;

    always_ff @(posedge pclk)
    begin
        if (tx_push_ok)
            tx_mem[tx_wp_q] <= pwdata[7:0];
        if (rx_push_ok)
            rx_mem[rx_wp_q] <= rx_byte;
    end

    // transmit pointers and fill
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_wp_q <= 8'h00;
            tx_rp_q <= 8'h00;
            tx_fill_q <= 8'h00;
        end
        else if (tx_qrst)
        begin
            tx_wp_q <= 8'h00;
            tx_rp_q <= 8'h00;
            tx_fill_q <= 8'h00;
        end
        else
        begin
            if (tx_push_ok)
                tx_wp_q <= wrap(tx_wp_q, cfg_q.tx_queue_length);
            if (tx_pop_ok)
                tx_rp_q <= wrap(tx_rp_q, cfg_q.tx_queue_length);
            tx_fill_q <= tx_fill_q + {7'h00, tx_push_ok} - {7'h00, tx_pop_ok};
        end
    end

    // receive pointers and fill
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_wp_q <= 8'h00;
            rx_rp_q <= 8'h00;
            rx_fill_q <= 8'h00;
        end
        else if (rx_qrst)
        begin
            rx_wp_q <= 8'h00;
            rx_rp_q <= 8'h00;
            rx_fill_q <= 8'h00;
        end
        else
        begin
            if (rx_push_ok)
                rx_wp_q <= wrap(rx_wp_q, cfg_q.rx_queue_length);
            if (rx_pop_ok)
                rx_rp_q <= wrap(rx_rp_q, cfg_q.rx_queue_length);
            rx_fill_q <= rx_fill_q + {7'h00, rx_push_ok} - {7'h00, rx_pop_ok};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shifter: mode 0, sample on rise, drive on fall
    wire logic lsb = cfg_q.low_bit_first_order;
    assign rx_byte = lsb ? {mosi_s_q[1], rx_sh_q[7:1]} : {rx_sh_q[6:0], mosi_s_q[1]};
    assign byte_done = sck_rise && bit_cnt_q == 3'h7;
    // next byte is taken at frame start and after each completed byte
    logic miso_idle_q;
    wire logic frame_start = frame && miso_idle_q;
    assign tx_load = byte_done || frame_start;
    wire logic [7:0] tx_next = tx_empty ? 8'h00 : tx_mem[tx_rp_q];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            bit_cnt_q <= 3'h0;
            rx_sh_q <= 8'h00;
            tx_sh_q <= 8'h00;
            miso_idle_q <= 1'b1;
            tx_got_q <= 1'b0;
            spi_miso_o <= 1'b0;
            spi_miso_oe_n <= 1'b1;
        end
        else if (!frame)
        begin
            bit_cnt_q <= 3'h0;
            miso_idle_q <= 1'b1;
            spi_miso_oe_n <= 1'b1;
        end
        else
        begin
            miso_idle_q <= 1'b0;
            spi_miso_oe_n <= 1'b0;
            if (sck_rise)
            begin
                rx_sh_q <= rx_byte;
                bit_cnt_q <= bit_cnt_q + 3'h1;
            end
            if (tx_load)
            begin
                tx_sh_q <= tx_next;
                tx_got_q <= !tx_empty;
                spi_miso_o <= lsb ? tx_next[0] : tx_next[7];
            end
            else if (sck_fall && bit_cnt_q != 3'h0)
            begin
                tx_sh_q <= lsb ? {1'b0, tx_sh_q[7:1]} : {tx_sh_q[6:0], 1'b0};
                spi_miso_o <= lsb ? tx_sh_q[1] : tx_sh_q[6];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // receive idle timeout
    logic [6:0] us_cnt_q;
    logic [11:0] tmo_cnt_q;
    logic tmo_hit;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            us_cnt_q <= 7'h00;
            tmo_cnt_q <= 12'h000;
        end
        else if (byte_done || rx_empty)
        begin
            us_cnt_q <= 7'h00;
            tmo_cnt_q <= 12'h000;
        end
        else if (us_cnt_q == 7'(US_CYCLES - 1))
        begin
            us_cnt_q <= 7'h00;
            if (tmo_cnt_q != 12'hfff)
                tmo_cnt_q <= tmo_cnt_q + 12'h001;
        end
        else
            us_cnt_q <= us_cnt_q + 7'h01;
    end
    // zero means never; the saturated count would otherwise wrap onto it
    assign tmo_hit = !rx_empty && !byte_done && us_cnt_q == 7'(US_CYCLES - 1) &&
                     cfg_q.rx_idle_timeout_us != 12'h000 &&
                     tmo_cnt_q + 12'h001 == cfg_q.rx_idle_timeout_us;

    ////////////////////////////////////////////////////////////////////
    // interrupt sources, sticky, write one to clear, set wins
    logic [8:0] irq_st_q;
    logic [8:0] ev;
    wire logic [7:0] tx_fill_n = tx_fill_q - {7'h00, tx_pop_ok};
    always_comb
    begin
        ev = 9'h000;
        ev[sqp_pkg::IRQ_RX_FIRST] = rx_push_ok && rx_empty;
        ev[sqp_pkg::IRQ_TX_FINAL] = tx_pop_ok && tx_fill_q == 8'h01;
        ev[sqp_pkg::IRQ_RX_RISE] = rx_push_ok && rx_fill_q == cfg_q.rx_fill_threshold;
        ev[sqp_pkg::IRQ_TX_DROP] = tx_pop_ok && tx_fill_n == cfg_q.tx_fill_threshold;
        ev[sqp_pkg::IRQ_RX_OVF] = byte_done && rx_full;
        ev[sqp_pkg::IRQ_TX_OVF] = tx_push && tx_full;
        ev[sqp_pkg::IRQ_RX_UNF] = rx_pop && rx_empty;
        ev[sqp_pkg::IRQ_TX_UNF] = tx_load && tx_empty;
        ev[sqp_pkg::IRQ_RX_TMO] = tmo_hit;
    end
    wire logic st_clr = wr && hit(paddr, sqp_pkg::OFS_IRQ_STAT);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_st_q <= 9'h000;
            irq <= 1'b0;
        end
        else
        begin
            irq_st_q <= (irq_st_q & ~(st_clr ? pwdata[8:0] : 9'h000)) | ev;
            irq <= |(((irq_st_q & ~(st_clr ? pwdata[8:0] : 9'h000)) | ev) & irq_en_q);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb read mux and answer, one wait state
    logic [31:0] rd_d;
    always_comb
    begin
        rd_d = 32'h0000_0000;
        unique case (paddr[7:2])
            sqp_pkg::OFS_CTRL[7:2]: rd_d = {30'h0, cfg_q.low_bit_first_order, cfg_q.enable};
            sqp_pkg::OFS_QLEN[7:2]: rd_d = {16'h0, cfg_q.rx_queue_length, cfg_q.tx_queue_length};
            sqp_pkg::OFS_THRESH[7:2]:
                rd_d = {16'h0, cfg_q.rx_fill_threshold, cfg_q.tx_fill_threshold};
            sqp_pkg::OFS_TIMEOUT[7:2]: rd_d = {20'h0, cfg_q.rx_idle_timeout_us};
            sqp_pkg::OFS_IRQ_EN[7:2]: rd_d = {23'h0, irq_en_q};
            sqp_pkg::OFS_IRQ_STAT[7:2]: rd_d = {23'h0, irq_st_q};
            sqp_pkg::OFS_RX_DATA[7:2]: rd_d = {24'h0, rx_empty ? 8'h00 : rx_mem[rx_rp_q]};
            sqp_pkg::OFS_FILL[7:2]: rd_d = {16'h0, rx_fill_q, tx_fill_q};
            sqp_pkg::OFS_STATUS[7:2]:
                rd_d = {28'h0, tx_fill_q > cfg_q.tx_fill_threshold,
                        rx_fill_q > cfg_q.rx_fill_threshold, !tx_empty, !rx_empty};
            default: rd_d = 32'h0000_0000;
        endcase
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            pready <= 1'b0;
        end
        else
        begin
            // registered answer: pready one cycle into the access phase
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata <= rd_d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    fill_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
        rx_push_ok && !rx_pop_ok && !rx_qrst |=> rx_fill_q == $past(rx_fill_q) + 8'h01)
        else $error("rx fill did not grow");
    qreset_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_qrst |=> tx_fill_q == 8'h00 && tx_wp_q == 8'h00)
        else $error("tx queue reset failed");
    miso_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        sel_s_q[1] |=> spi_miso_oe_n)
        else $error("miso driven outside frame");
    irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
        |(irq_st_q & irq_en_q) |-> irq)
        else $error("pending source without irq");
    tx_push_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_push_ok && !tx_pop_ok && !tx_qrst |=> tx_fill_q == $past(tx_fill_q) + 8'h01)
        else $error("tx write not appended");
    disable_a: assert property (@(posedge pclk) disable iff (!presetn)
        !cfg_q.enable |=> bit_cnt_q == 3'h0)
        else $error("shifter active while disabled");
    ovf_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_push && tx_full && !tx_qrst |=> irq_st_q[sqp_pkg::IRQ_TX_OVF])
        else $error("tx overflow not flagged");
    tmo_a: assert property (@(posedge pclk) disable iff (!presetn)
        tmo_hit |=> irq_st_q[sqp_pkg::IRQ_RX_TMO])
        else $error("timeout not flagged");
endmodule : sqp_spi_slave

// File: tb/sqp_spi_master.sv
// Purpose: behavioural spi master facing the slave port
// Assumes: mode 0, select active low, sck idle low between frames
// Notes: miso is trusted only while the slave drives it
`timescale 1ns/1ps
module sqp_spi_master (
    // link
    output logic spi_sck,
    output logic spi_sel_n,
    output logic spi_mosi,
    input wire logic spi_miso_o,
    input wire logic spi_miso_oe_n
);
    logic drove;
    // idle levels before the first frame
    initial
    begin
        spi_sck = 1'b0;
        spi_sel_n = 1'b1;
        spi_mosi = 1'b0;
        drove = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // one framed byte; sck stands still outside the frame
    task automatic xfer(input logic lsb, input logic [7:0] tx, output logic [7:0] rx);
        int b;
        drove = 1'b0;
        spi_sel_n = 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            b = lsb ? i : 7 - i;
            spi_mosi = tx[b];
            #62.5 spi_sck = 1'b1;
            // undriven wire reads as noise, not as the last bit
            rx[b] = (spi_miso_oe_n === 1'b0) ? spi_miso_o : ~spi_miso_o;
            if (spi_miso_oe_n === 1'b0)
                drove = 1'b1;
            #62.5 spi_sck = 1'b0;
        end
        #62.5 spi_sel_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask : xfer
endmodule : sqp_spi_master

// File: tb/tb_top.sv
// Purpose: self-checking bench for the spi slave queue port
// Assumes: apb master here, spi master in its own model
// Notes: one microsecond shortened to two pclk cycles
`timescale 1ns/1ps
module tb_top;
    localparam int USC = 2;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, irq;
    logic [7:0] paddr, got;
    logic [31:0] pwdata, prdata, rdat;
    logic spi_sck, spi_sel_n, spi_mosi, spi_miso_o, spi_miso_oe_n;
    int bad_count, check_count;
    sqp_spi_slave #(.DEPTH(255), .US_CYCLES(USC)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .spi_sck(spi_sck),
        .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
        .spi_miso_oe_n(spi_miso_oe_n), .irq(irq));
    sqp_spi_master mst (
        .spi_sck(spi_sck), .spi_sel_n(spi_sel_n), .spi_mosi(spi_mosi),
        .spi_miso_o(spi_miso_o), .spi_miso_oe_n(spi_miso_oe_n));
    // 125 MHz system clock
    initial
    begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (n >= 50)
            chk("pready", 1, 0);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // read a word and compare the masked bits
    task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
        input logic [31:0] m = 32'hffffffff);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rdat & m);
    endtask : rd
    ////////////////////////////////////////////////////////////////////////
    // reset values, idle pins and an unmapped word
    task automatic t_reset;
        chk("oe_n idle", 1, spi_miso_oe_n);
        chk("irq idle", 0, irq);
        rd("qlen", sqp_pkg::OFS_QLEN, 32'h0000ffff);
        rd("thresh", sqp_pkg::OFS_THRESH, 32'h0);
        rd("timeout", sqp_pkg::OFS_TIMEOUT, 32'h0);
        rd("irq_en", sqp_pkg::OFS_IRQ_EN, 32'h0);
        rd("status", sqp_pkg::OFS_STATUS, 32'h0);
        apb(1'b0, 8'h2c, 32'h0);
        chk("slverr", 1, rerr);
    endtask : t_reset
    // short queues, third write overflows
    task automatic t_txq;
        apb(1'b1, sqp_pkg::OFS_CTRL, 32'h1);
        apb(1'b1, sqp_pkg::OFS_QLEN, 32'h0202);
        apb(1'b1, sqp_pkg::OFS_THRESH, 32'h0001);
        rd("qlen", sqp_pkg::OFS_QLEN, 32'h0202);
        rd("thresh", sqp_pkg::OFS_THRESH, 32'h0001);
        apb(1'b1, sqp_pkg::OFS_TX_DATA, 32'h3c);
        apb(1'b1, sqp_pkg::OFS_TX_DATA, 32'hc3);
        apb(1'b1, sqp_pkg::OFS_TX_DATA, 32'h77);
        rd("fill", sqp_pkg::OFS_FILL, 32'h0002);
        rd("status", sqp_pkg::OFS_STATUS, 32'h000a);
        rd("irq_stat", sqp_pkg::OFS_IRQ_STAT, 32'h0020);
        apb(1'b1, sqp_pkg::OFS_IRQ_STAT, 32'h1ff);
    endtask : t_txq
    // both bit orders, underflow, overflow and masking
    task automatic t_xfer;
        mst.xfer(1'b0, 8'ha5, got);
        chk("miso msb", 32'h3c, {24'h0, got});
        rd("fill", sqp_pkg::OFS_FILL, 32'h0101);
        rd("status", sqp_pkg::OFS_STATUS, 32'h0007);
        rd("irq_stat", sqp_pkg::OFS_IRQ_STAT, 32'h000d);
        rd("rx byte", sqp_pkg::OFS_RX_DATA, 32'h00a5);
        rd("fill", sqp_pkg::OFS_FILL, 32'h0001);
        apb(1'b1, sqp_pkg::OFS_IRQ_STAT, 32'h1ff);
        apb(1'b1, sqp_pkg::OFS_IRQ_EN, 32'h010);
        apb(1'b1, sqp_pkg::OFS_CTRL, 32'h3);
        mst.xfer(1'b1, 8'h1e, got);
        chk("miso lsb", 32'hc3, {24'h0, got});
        mst.xfer(1'b1, 8'h00, got);
        chk("miso empty", 32'h0, {24'h0, got});
        // rx queue of two is now full, this byte is lost
        mst.xfer(1'b1, 8'hff, got);
        rd("irq_stat", sqp_pkg::OFS_IRQ_STAT, 32'h0092, 32'h0092);
        chk("irq", 1, irq);
        apb(1'b1, sqp_pkg::OFS_IRQ_EN, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq masked", 0, irq);
        rd("rx oldest", sqp_pkg::OFS_RX_DATA, 32'h001e);
        apb(1'b1, sqp_pkg::OFS_IRQ_STAT, 32'h1ff);
        rd("irq_stat clr", sqp_pkg::OFS_IRQ_STAT, 32'h0);
    endtask : t_xfer
    // each queue reset alone, then both
    task automatic t_qreset;
        apb(1'b1, sqp_pkg::OFS_TX_DATA, 32'h5a);
        rd("fill", sqp_pkg::OFS_FILL, 32'h0101);
        apb(1'b1, sqp_pkg::OFS_QRESET, 32'h1);
        rd("fill tx rst", sqp_pkg::OFS_FILL, 32'h0100);
        apb(1'b1, sqp_pkg::OFS_TX_DATA, 32'h11);
        apb(1'b1, sqp_pkg::OFS_QRESET, 32'h2);
        rd("fill rx rst", sqp_pkg::OFS_FILL, 32'h0001);
        apb(1'b1, sqp_pkg::OFS_TX_DATA, 32'h22);
        mst.xfer(1'b1, 8'h33, got);
        apb(1'b1, sqp_pkg::OFS_QRESET, 32'h3);
        rd("fill both rst", sqp_pkg::OFS_FILL, 32'h0);
        rd("status", sqp_pkg::OFS_STATUS, 32'h0);
    endtask : t_qreset
    // idle receive queue raises the timeout after the programmed span
    task automatic t_timeout;
        apb(1'b1, sqp_pkg::OFS_TIMEOUT, 32'd100);
        rd("timeout", sqp_pkg::OFS_TIMEOUT, 32'd100);
        apb(1'b1, sqp_pkg::OFS_IRQ_EN, 32'h100);
        mst.xfer(1'b1, 8'h42, got);
        apb(1'b1, sqp_pkg::OFS_IRQ_STAT, 32'h1ff);
        rd("tmo early", sqp_pkg::OFS_IRQ_STAT, 32'h0, 32'h100);
        repeat (100 * USC + 20) @(posedge pclk);
        rd("tmo fired", sqp_pkg::OFS_IRQ_STAT, 32'h100, 32'h100);
        chk("irq tmo", 1, irq);
        apb(1'b1, sqp_pkg::OFS_TIMEOUT, 32'h0);
        apb(1'b1, sqp_pkg::OFS_IRQ_EN, 32'h0);
    endtask : t_timeout
    // disabled slave neither drives miso nor takes bytes
    task automatic t_disable;
        apb(1'b1, sqp_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, sqp_pkg::OFS_QRESET, 32'h3);
        mst.xfer(1'b0, 8'h81, got);
        chk("driven off", 0, {31'h0, mst.drove});
        rd("fill off", sqp_pkg::OFS_FILL, 32'h0);
        apb(1'b1, sqp_pkg::OFS_CTRL, 32'h1);
        mst.xfer(1'b0, 8'h81, got);
        chk("driven on", 1, {31'h0, mst.drove});
        rd("fill on", sqp_pkg::OFS_FILL, 32'h0100);
    endtask : t_disable
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_of_test
    // main sequence after a 20-cycle reset
    initial
    begin
        bad_count = 0;
        check_count = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_txq();
        t_xfer();
        t_qreset();
        t_timeout();
        t_disable();
        end_of_test();
    end
    // a hang counts as a mismatch; the run needs well under this span
    initial
    begin
        #400000;
        chk("watchdog", 0, 1);
        end_of_test();
    end
endmodule : tb_top
